// ### sqm_regs.svh
// Register offsets, field positions, reset values and fixed-point layout
`ifndef SQM_REGS_SVH
`define SQM_REGS_SVH

`define SQM_CTRL_OFS 4'h0
`define SQM_STAT_OFS 4'h4
`define SQM_CNT_OFS 4'h8
`define SQM_CTRL_EN_BIT 0
`define SQM_STAT_BUSY_BIT 0
`define SQM_STAT_PEND_BIT 1
`define SQM_CTRL_RST 1'b1
`define SQM_FRAC_BITS 8
`define SQM_EXP_BIAS 8'h7f
`define SQM_LOD_FLOOR 16'h8000
`define SQM_ALL_CHAN 4'hf
`define SQM_RED_GREEN 4'h3

`endif

// ### sqm_pkg.sv
// Types shared by the surface query message block
package sqm_pkg;

    typedef enum logic [1:0] {
        msg_sample_count,
        msg_detail_level,
        msg_surface_size
    } sqm_msg_t;

    typedef enum logic [2:0] {
        surface_kind_linear,
        surface_kind_planar,
        surface_kind_volume,
        surface_kind_cube,
        surface_kind_none
    } sqm_surf_t;

    typedef enum logic [1:0] {
        st_idle,
        st_calc,
        st_resp
    } sqm_state_t;

endpackage

// ### sqm_fix2flt.sv
// Signed 8.8 fixed point to single precision float converter
`timescale 1ns/1ps
`include "sqm_regs.svh"

module sqm_fix2flt (
    input wire logic [15:0] fix_val,
    output logic [31:0] flt_val
);

    logic [16:0] mag;
    logic [4:0] lead;
    logic [39:0] shifted;
    logic [7:0] expo;

    always_comb begin
        mag = fix_val[15] ? 17'(~{fix_val[15], fix_val} + 17'h1) : {1'b0, fix_val};
        lead = 5'h0;
        for (int i = 0; i < 17; i++) begin
            if (mag[i]) begin
                lead = 5'(i);
            end
        end
        shifted = {mag, 23'h0} >> lead;
        expo = 8'(`SQM_EXP_BIAS + {3'h0, lead} - 8'(`SQM_FRAC_BITS));
        if (mag == 17'h0) begin
            flt_val = 32'h0;
        end else begin
            flt_val = {fix_val[15], expo, shifted[22:0]};
        end
    end

endmodule

// ### sqm_core.sv
// Surface query message engine: sample count, detail level, surface size
// Notes on behaviour
// - Sample count red, palette alpha, no sampling
// - Alpha returns palette index plus one
// - Detail level: clamped red, unclamped green, floats
// - Detail level blue, alpha undefined, maskable
// - Gradients from neighbours; three coordinates, extras ignored
// - Size query returns dimensions and mip count
// - 1D/2D depth is slices, else 1
// - Level parameter unsigned, scales width/height/depth
// - Out-of-range level gives zero red/green/blue
// - Size query ignores sampler pointer and index
`timescale 1ns/1ps
`include "sqm_regs.svh"

module sqm_core
    import sqm_pkg::*;
#(
    parameter int DIM_W = 14,
    parameter int COORD_W = 24
) (
    input wire logic mclk,
    input wire logic nrst,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Query message from the shader unit
    input wire logic msg_valid,
    output logic msg_ready,
    input wire sqm_msg_t msg_kind,
    input wire sqm_surf_t surf_kind,
    input wire logic surf_array,
    input wire logic [DIM_W-1:0] surf_width,
    input wire logic [DIM_W-1:0] surf_height,
    input wire logic [DIM_W-1:0] surf_depth,
    input wire logic [3:0] surf_mip_count,
    input wire logic [31:0] surf_samples,
    input wire logic [31:0] surf_palette,
    input wire logic [31:0] msg_level,
    input wire logic [3:0] msg_chan_mask,
    input wire logic [15:0] smp_min_lod,
    input wire logic [15:0] smp_max_lod,
    input wire logic [3*COORD_W-1:0] crd_here,
    input wire logic [3*COORD_W-1:0] crd_right,
    input wire logic [3*COORD_W-1:0] crd_below,
    // Returned channels
    output logic rsp_valid,
    input wire logic rsp_ready,
    output logic [31:0] rsp_red,
    output logic [31:0] rsp_green,
    output logic [31:0] rsp_blue,
    output logic [31:0] rsp_alpha,
    output logic [3:0] rsp_mask
);

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic en_reg, en_next;
    logic wait_reg, wait_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [31:0] cnt_reg, cnt_next;
    sqm_state_t state_reg, state_next;
    logic rsp_valid_reg;

    always_comb begin
        en_next = en_reg;
        wait_next = wait_reg;
        rdata_next = rdata_reg;
        if ((avs_read || avs_write) && wait_reg) begin
            wait_next = 1'b0;
            rdata_next = 32'h0;
            if (avs_read) begin
                if (avs_address == `SQM_CTRL_OFS) begin
                    rdata_next[`SQM_CTRL_EN_BIT] = en_reg;
                end else if (avs_address == `SQM_STAT_OFS) begin
                    rdata_next[`SQM_STAT_BUSY_BIT] = (state_reg != st_idle);
                    rdata_next[`SQM_STAT_PEND_BIT] = rsp_valid_reg;
                end else if (avs_address == `SQM_CNT_OFS) begin
                    rdata_next = cnt_reg;
                end
            end
        end else if (!wait_reg) begin
            wait_next = 1'b1;
            if (avs_write && avs_address == `SQM_CTRL_OFS && avs_byteenable[0]) begin
                en_next = avs_writedata[`SQM_CTRL_EN_BIT];
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            en_reg <= `SQM_CTRL_RST;
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0;
        end else begin
            en_reg <= en_next;
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
        end
    end

    assign avs_waitrequest = wait_reg;
    assign avs_readdata = rdata_reg;

    // ------------------------------------------------------------
    // Detail level from neighbour gradients
    // ------------------------------------------------------------
    logic [COORD_W-1:0] grad_max;
    logic [COORD_W-1:0] diff_x, diff_y;
    logic [1:0] axes;
    logic [4:0] lead;
    logic [COORD_W+7:0] frac_sh;
    logic [15:0] lod_raw;
    logic [15:0] lod_clamp;
    logic [31:0] flt_raw, flt_clamp;

    always_comb begin
        grad_max = '0;
        diff_x = '0;
        diff_y = '0;
        case (surf_kind)
            surface_kind_linear: axes = 2'h1;
            surface_kind_volume: axes = 2'h3;
            default: axes = 2'h2;
        endcase
        // Only axes the surface needs count; the rest are ignored
        for (int a = 0; a < 3; a++) begin
            if (a < int'(axes)) begin
                diff_x = (crd_right[a*COORD_W +: COORD_W] > crd_here[a*COORD_W +: COORD_W])
                    ? crd_right[a*COORD_W +: COORD_W] - crd_here[a*COORD_W +: COORD_W]
                    : crd_here[a*COORD_W +: COORD_W] - crd_right[a*COORD_W +: COORD_W];
                diff_y = (crd_below[a*COORD_W +: COORD_W] > crd_here[a*COORD_W +: COORD_W])
                    ? crd_below[a*COORD_W +: COORD_W] - crd_here[a*COORD_W +: COORD_W]
                    : crd_here[a*COORD_W +: COORD_W] - crd_below[a*COORD_W +: COORD_W];
                if (diff_x > grad_max) begin
                    grad_max = diff_x;
                end
                if (diff_y > grad_max) begin
                    grad_max = diff_y;
                end
            end
        end
        lead = 5'h0;
        for (int i = 0; i < COORD_W; i++) begin
            if (grad_max[i]) begin
                lead = 5'(i);
            end
        end
        frac_sh = {grad_max, 8'h0} >> lead;
        // Approximate log2 of the largest gradient
        if (grad_max == '0) begin
            lod_raw = `SQM_LOD_FLOOR;
        end else begin
            lod_raw = {8'({3'h0, lead} - 8'(`SQM_FRAC_BITS)), frac_sh[7:0]};
        end
        lod_clamp = lod_raw;
        if ($signed(lod_clamp) < $signed(smp_min_lod)) begin
            lod_clamp = smp_min_lod;
        end
        if ($signed(lod_clamp) > $signed(smp_max_lod)) begin
            lod_clamp = smp_max_lod;
        end
    end

    sqm_fix2flt u_flt_clamp (
        .fix_val(lod_clamp),
        .flt_val(flt_clamp)
    );

    sqm_fix2flt u_flt_raw (
        .fix_val(lod_raw),
        .flt_val(flt_raw)
    );

    // ------------------------------------------------------------
    // Surface size and channel selection
    // ------------------------------------------------------------
    logic [31:0] w_lvl, h_lvl, d_lvl, slices;
    logic lvl_ok;
    logic [31:0] red_c, green_c, blue_c, alpha_c;
    logic [3:0] mask_c;

    always_comb begin
        // Level taken as unsigned 32 bits; negatives land out of range
        lvl_ok = msg_level < {28'h0, surf_mip_count};
        w_lvl = 32'({18'h0, surf_width} + 32'h1) >> msg_level[4:0];
        h_lvl = 32'({18'h0, surf_height} + 32'h1) >> msg_level[4:0];
        d_lvl = 32'({18'h0, surf_depth} + 32'h1) >> msg_level[4:0];
        slices = surf_array ? 32'({18'h0, surf_depth} + 32'h1) : 32'h1;
        red_c = 32'h0;
        green_c = 32'h0;
        blue_c = 32'h0;
        alpha_c = 32'h0;
        mask_c = `SQM_ALL_CHAN;
        case (msg_kind)
            msg_sample_count: begin
                // Surface not sampled, sampler state unused
                red_c = surf_samples;
                alpha_c = 32'(surf_palette + 32'h1);
            end
            msg_detail_level: begin
                red_c = flt_clamp;
                green_c = flt_raw;
                // Blue and alpha carry no value and may be masked off
                mask_c = `SQM_RED_GREEN | msg_chan_mask;
            end
            default: begin
                // Sampler pointer and index play no part here
                alpha_c = {28'h0, surf_mip_count};
                case (surf_kind)
                    surface_kind_linear: begin
                        red_c = w_lvl;
                        green_c = slices;
                    end
                    surface_kind_planar: begin
                        red_c = w_lvl;
                        green_c = h_lvl;
                        blue_c = slices;
                    end
                    surface_kind_volume: begin
                        red_c = w_lvl;
                        green_c = h_lvl;
                        blue_c = d_lvl;
                    end
                    surface_kind_cube: begin
                        red_c = w_lvl;
                        green_c = h_lvl;
                        blue_c = surf_array ? slices : 32'h0;
                    end
                    default: begin
                        alpha_c = 32'h0;
                    end
                endcase
                if (!lvl_ok) begin
                    red_c = 32'h0;
                    green_c = 32'h0;
                    blue_c = 32'h0;
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // Message sequencing
    // ------------------------------------------------------------
    logic msg_ready_reg, msg_ready_next;
    logic rsp_valid_next;
    logic [31:0] red_reg, red_next, green_reg, green_next;
    logic [31:0] blue_reg, blue_next, alpha_reg, alpha_next;
    logic [3:0] mask_reg, mask_next;

    always_comb begin
        state_next = state_reg;
        rsp_valid_next = rsp_valid_reg;
        red_next = red_reg;
        green_next = green_reg;
        blue_next = blue_reg;
        alpha_next = alpha_reg;
        mask_next = mask_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            st_idle: begin
                if (msg_valid && msg_ready_reg) begin
                    state_next = st_calc;
                    red_next = red_c;
                    green_next = green_c;
                    blue_next = blue_c;
                    alpha_next = alpha_c;
                    mask_next = mask_c;
                end
            end
            st_calc: begin
                state_next = st_resp;
                rsp_valid_next = 1'b1;
            end
            default: begin
                if (rsp_ready) begin
                    state_next = st_idle;
                    rsp_valid_next = 1'b0;
                    cnt_next = 32'(cnt_reg + 32'h1);
                end
            end
        endcase
        msg_ready_next = (state_next == st_idle) && en_next;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= st_idle;
            msg_ready_reg <= 1'b0;
            rsp_valid_reg <= 1'b0;
            red_reg <= 32'h0;
            green_reg <= 32'h0;
            blue_reg <= 32'h0;
            alpha_reg <= 32'h0;
            mask_reg <= 4'h0;
            cnt_reg <= 32'h0;
        end else begin
            state_reg <= state_next;
            msg_ready_reg <= msg_ready_next;
            rsp_valid_reg <= rsp_valid_next;
            red_reg <= red_next;
            green_reg <= green_next;
            blue_reg <= blue_next;
            alpha_reg <= alpha_next;
            mask_reg <= mask_next;
            cnt_reg <= cnt_next;
        end
    end

    assign msg_ready = msg_ready_reg;
    assign rsp_valid = rsp_valid_reg;
    assign rsp_red = red_reg;
    assign rsp_green = green_reg;
    assign rsp_blue = blue_reg;
    assign rsp_alpha = alpha_reg;
    assign rsp_mask = mask_reg;

endmodule

// ### sqm_core_chk.sv
// Assertion checker for the surface query engine
`timescale 1ns/1ps
module sqm_core_chk
    import sqm_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic msg_valid,
    input wire logic msg_ready,
    input wire sqm_msg_t msg_kind,
    input wire sqm_surf_t surf_kind,
    input wire logic [3:0] surf_mip_count,
    input wire logic [31:0] surf_samples,
    input wire logic [31:0] surf_palette,
    input wire logic [31:0] msg_level,
    input wire logic [3:0] msg_chan_mask,
    input wire logic rsp_valid,
    input wire logic rsp_ready,
    input wire logic [31:0] rsp_red,
    input wire logic [31:0] rsp_green,
    input wire logic [31:0] rsp_blue,
    input wire logic [31:0] rsp_alpha,
    input wire logic [3:0] rsp_mask
);
typedef struct packed {
    sqm_msg_t k;
    sqm_surf_t s;
    logic [31:0] smp;
    logic [31:0] pal;
    logic [31:0] lvl;
    logic [3:0] mip;
    logic [3:0] msk;
} sqm_cap_t;
sqm_cap_t cap_reg, cap_next;
// ------------------------------
// Query fields held from the take
// ------------------------------
always_comb begin
    cap_next = cap_reg;
    if (msg_valid && msg_ready) begin
        cap_next = '{msg_kind, surf_kind, surf_samples, surf_palette, msg_level,
            surf_mip_count, msg_chan_mask};
    end
end
always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        cap_reg <= '0;
    end else begin
        cap_reg <= cap_next;
    end
end
default clocking cb @(posedge mclk); endclocking
default disable iff (!nrst);
property p_ans;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
endproperty
a_ans: assert property (p_ans) else $error("bus answer wrong");
property p_unmap;
    avs_read && avs_waitrequest && !(avs_address inside {4'h0, 4'h4, 4'h8})
        |=> avs_readdata == 32'h0;
endproperty
a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
property p_take;
    msg_valid && msg_ready |=> !msg_ready ##[1:2] rsp_valid;
endproperty
a_take: assert property (p_take) else $error("response late");
property p_hold;
    rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_red) && $stable(rsp_alpha)
        && $stable(rsp_mask);
endproperty
a_hold: assert property (p_hold) else $error("response not held");
property p_cnt;
    rsp_valid && cap_reg.k == msg_sample_count
        |-> rsp_red == cap_reg.smp && rsp_alpha == cap_reg.pal + 32'h1;
endproperty
a_cnt: assert property (p_cnt) else $error("sample count wrong");
property p_mask;
    rsp_valid && cap_reg.k == msg_detail_level |-> rsp_mask == (4'h3 | cap_reg.msk);
endproperty
a_mask: assert property (p_mask) else $error("detail mask wrong");
property p_oob;
    rsp_valid && cap_reg.k == msg_surface_size && cap_reg.lvl >= {28'h0, cap_reg.mip}
        |-> rsp_red == 32'h0 && rsp_green == 32'h0 && rsp_blue == 32'h0;
endproperty
a_oob: assert property (p_oob) else $error("level out of range");
property p_mip;
    rsp_valid && cap_reg.k == msg_surface_size && cap_reg.s != surface_kind_none
        |-> rsp_alpha == {28'h0, cap_reg.mip};
endproperty
a_mip: assert property (p_mip) else $error("mip count wrong");
endmodule
bind sqm_core sqm_core_chk u_sqm_core_chk (.mclk, .nrst, .avs_address, .avs_read,
    .avs_write, .avs_readdata, .avs_waitrequest, .msg_valid, .msg_ready, .msg_kind,
    .surf_kind, .surf_mip_count, .surf_samples, .surf_palette, .msg_level, .msg_chan_mask,
    .rsp_valid, .rsp_ready, .rsp_red, .rsp_green, .rsp_blue, .rsp_alpha, .rsp_mask);

// ### sqm_sender.sv
// Shader unit model: offers queries and takes responses
`timescale 1ns/1ps
module sqm_sender (
    input wire logic mclk,
    input wire logic msg_ready,
    input wire logic rsp_valid,
    output logic msg_valid,
    output logic rsp_ready
);
// ---------------
// Query handshake
// ---------------
initial begin
    msg_valid = 1'b0;
    rsp_ready = 1'b0;
end
// Only query messages offered, never gather
task automatic offer();
    msg_valid <= 1'b1;
    @(posedge mclk);
    while (!msg_ready) @(posedge mclk);
    msg_valid <= 1'b0;
endtask
task automatic wait_rsp();
    @(posedge mclk);
    while (!rsp_valid) @(posedge mclk);
endtask
// Channels taken as 32-bit words
task automatic accept(input int stall);
    repeat (stall) @(posedge mclk);
    rsp_ready <= 1'b1;
    @(posedge mclk);
    rsp_ready <= 1'b0;
endtask
endmodule

// ### sqm_tb_top.sv
// Testbench for the surface query engine
`timescale 1ns/1ps
module sqm_tb_top
    import sqm_pkg::*;
;
logic mclk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0, surf_array = 1'b0;
logic msg_valid, rsp_ready, rsp_valid, msg_ready, avs_waitrequest;
logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf, surf_mip_count = 4'h5;
logic [3:0] msg_chan_mask = 4'h0, rsp_mask;
logic [31:0] avs_writedata = 32'h0, surf_samples = 32'h4, surf_palette = 32'h2;
logic [31:0] msg_level = 32'h0, avs_readdata, rsp_red, rsp_green, rsp_blue, rsp_alpha, q;
logic [13:0] surf_width = 14'h63, surf_height = 14'h3f, surf_depth = 14'h7;
logic [15:0] smp_min_lod = 16'h0, smp_max_lod = 16'h0100;
logic [71:0] crd_here = 72'h0, crd_right = 72'h400, crd_below = 72'hff0000_000000_000000;
sqm_msg_t msg_kind = msg_sample_count;
sqm_surf_t surf_kind = surface_kind_planar;
int err_count = 0, n_tests = 0;
always #12.5 mclk = ~mclk;
sqm_core u_sqm_core (.mclk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .msg_valid, .msg_ready, .msg_kind,
    .surf_kind, .surf_array, .surf_width, .surf_height, .surf_depth, .surf_mip_count,
    .surf_samples, .surf_palette, .msg_level, .msg_chan_mask, .smp_min_lod, .smp_max_lod,
    .crd_here, .crd_right, .crd_below, .rsp_valid, .rsp_ready, .rsp_red, .rsp_green,
    .rsp_blue, .rsp_alpha, .rsp_mask);
sqm_sender u_sqm_sender (.mclk, .msg_ready, .rsp_valid, .msg_valid, .rsp_ready);
// -------------
// Shared tasks
// -------------
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
        err_count++;
        $display("BAD %0t got %h expected %h", $time, got, exp);
    end
endtask
task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge mclk);
    while (avs_waitrequest) @(posedge mclk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
endtask
task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
endtask
task automatic run(input logic [31:0] r, g, b, a, input logic [3:0] m);
    u_sqm_sender.offer();
    surf_samples <= ~surf_samples;
    msg_level <= ~msg_level;
    surf_width <= ~surf_width;
    u_sqm_sender.wait_rsp();
    chk(rsp_red, r);
    chk(rsp_green, g);
    chk(rsp_blue, b);
    chk(rsp_alpha, a);
    chk({28'h0, rsp_mask}, {28'h0, m});
    rd(4'h4, 32'h3);
    u_sqm_sender.accept(n_tests % 3);
endtask
task automatic sz(input sqm_surf_t s, input logic ar, input logic [31:0] l, r, g, b, a);
    msg_kind <= msg_surface_size;
    surf_kind <= s;
    surf_array <= ar;
    surf_width <= 14'h63;
    msg_level <= l;
    run(r, g, b, a, 4'hf);
endtask
task automatic print_verdict();
    if (err_count == 0 && n_tests > 0) begin
        $display("All tests passed");
    end else begin
        $display("Some tests failed");
    end
    $finish;
endtask
// -------------
// Test sequence
// -------------
initial begin
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    rd(4'h0, 32'h1);
    rd(4'hc, 32'h0);
    bus(1'b1, 4'h8, 32'h5);
    rd(4'h8, 32'h0);
    run(32'h4, 32'h0, 32'h0, 32'h3, 4'hf);
    surf_kind <= surface_kind_none;
    surf_samples <= 32'h1;
    surf_palette <= 32'hffffffff;
    run(32'h1, 32'h0, 32'h0, 32'h0, 4'hf);
    sz(surface_kind_planar, 1'b0, 32'h1, 32'h32, 32'h20, 32'h1, 32'h5);
    sz(surface_kind_planar, 1'b1, 32'h1, 32'h32, 32'h20, 32'h8, 32'h5);
    sz(surface_kind_volume, 1'b0, 32'h2, 32'h19, 32'h10, 32'h2, 32'h5);
    sz(surface_kind_planar, 1'b0, 32'h4, 32'h6, 32'h4, 32'h1, 32'h5);
    sz(surface_kind_cube, 1'b0, 32'h5, 32'h0, 32'h0, 32'h0, 32'h5);
    sz(surface_kind_linear, 1'b0, 32'hffffffff, 32'h0, 32'h0, 32'h0, 32'h5);
    sz(surface_kind_linear, 1'b1, 32'h0, 32'h64, 32'h8, 32'h0, 32'h5);
    sz(surface_kind_cube, 1'b1, 32'h0, 32'h64, 32'h40, 32'h8, 32'h5);
    sz(surface_kind_cube, 1'b0, 32'h1, 32'h32, 32'h20, 32'h0, 32'h5);
    sz(surface_kind_linear, 1'b0, 32'h3, 32'hc, 32'h1, 32'h0, 32'h5);
    sz(surface_kind_none, 1'b0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0);
    msg_kind <= msg_detail_level;
    surf_kind <= surface_kind_planar;
    run(32'h3f800000, 32'h40000000, 32'h0, 32'h0, 4'h3);
    surf_kind <= surface_kind_linear;
    crd_below <= 72'h010000_000000;
    smp_min_lod <= 16'h0300;
    smp_max_lod <= 16'h0400;
    msg_chan_mask <= 4'hc;
    run(32'h40400000, 32'h40000000, 32'h0, 32'h0, 4'hf);
    surf_kind <= surface_kind_volume;
    crd_below <= 72'h020000_000000_000000;
    msg_chan_mask <= 4'h4;
    run(32'h40800000, 32'h41100000, 32'h0, 32'h0, 4'h7);
    bus(1'b1, 4'h0, 32'h0);
    repeat (2) @(posedge mclk);
    chk({31'h0, msg_ready}, 32'h0);
    bus(1'b1, 4'h0, 32'h1);
    rd(4'h0, 32'h1);
    rd(4'h8, 32'h10);
    rd(4'h4, 32'h0);
    print_verdict();
end
initial begin
    repeat (4000) @(posedge mclk);
    err_count++;
    print_verdict();
end
endmodule
